// >>> pkg/logger_regs_pkg.sv
// Constants for the logger mission control register bank
package logger_regs_pkg;
   localparam logic [9:0] ADDR_LOW_THR = 10'h20b;
   localparam logic [9:0] ADDR_HIGH_THR = 10'h20c;
   localparam logic [9:0] ADDR_RATE = 10'h20d;
   localparam logic [9:0] ADDR_CTRL = 10'h20e;
   localparam logic [9:0] ADDR_READOUT = 10'h211;
   localparam logic [9:0] ADDR_DLY_LO = 10'h212;
   localparam logic [9:0] ADDR_DLY_HI = 10'h213;
   localparam logic [9:0] ADDR_STATUS = 10'h214;
   localparam logic [9:0] ADDR_PAGE_LO = 10'h200;
   localparam logic [9:0] ADDR_PAGE_HI = 10'h213;
   // Control fields
   localparam int CTL_OSC = 7;
   localparam int CTL_CLR = 6;
   localparam int CTL_RSVD = 5;
   localparam int CTL_EN = 4;
   localparam int CTL_WRAP = 3;
   localparam int CTL_TLS = 2;
   localparam int CTL_THS = 1;
   localparam int CTL_TAS = 0;
   // Status fields
   localparam int ST_BUSY = 7;
   localparam int ST_CLR = 6;
   localparam int ST_MIP = 5;
   localparam int ST_SIP = 4;
   localparam int ST_TLF = 2;
   localparam int ST_THF = 1;
   localparam int ST_TAF = 0;
   localparam logic [7:0] CTL_RESET = 8'h80;
   localparam logic [7:0] CTL_WMASK = 8'hdf;
   // Temperature codes
   localparam logic [7:0] TEMP_UNDER = 8'h00;
   localparam logic [7:0] TEMP_OVER = 8'hfa;
   localparam logic [7:0] TEMP_MIN_OK = 8'h01;
   localparam logic [7:0] TEMP_MAX_OK = 8'hf9;
   // Timing
   localparam int CLK_MHZ = 200;
   localparam int WAKE_MS = 250;
   localparam int CONV_MS = 875;
   localparam int WAKE_CYC = WAKE_MS * 1000 * CLK_MHZ;
   localparam int CONV_CYC = (CONV_MS - WAKE_MS) * 1000 * CLK_MHZ;
   localparam logic [5:0] SEC_LAST = 6'h3b;
endpackage : logger_regs_pkg

// >>> verif/host_model.sv
// Register bus host model that drives the logger register strobes
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic i_clk_sys,
   input wire logic i_rvalid,
   input wire logic [7:0] i_rdata,
   output logic o_wr,
   output logic o_rd,
   output logic [9:0] o_addr,
   output logic [7:0] o_wdata
);
   // Idle bus before the first access
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 10'h000;
      o_wdata = 8'h00;
   end
   // Threshold code from twice the Celsius value
   function automatic logic [7:0] thr(input int c2);
      return 8'(c2 + 80);
   endfunction : thr
   // One write strobe; released lines show the inverse, never a stale copy
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      #1;
      o_wr = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(posedge i_clk_sys);
      #1;
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask : wr
   // One read strobe; answer stands for the cycle after the taking edge
   task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic ok);
      @(posedge i_clk_sys);
      #1;
      o_rd = 1'b1;
      o_addr = a;
      @(posedge i_clk_sys);
      #1;
      o_rd = 1'b0;
      o_addr = ~a;
      ok = i_rvalid;
      d = i_rdata;
   endtask : rd
endmodule : host_model
`default_nettype wire

// >>> verif/tb_logger_mission_control_regs.sv
// Self-checking bench for the logger mission control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_logger_mission_control_regs;
   logic clk_sys = 1'b0; // 200 MHz system clock
   logic rst_n = 1'b0; // Synchronous reset, active low
   logic tick = 1'b0, mem = 1'b0, clrc = 1'b0, alarm = 1'b0, under = 1'b0, over = 1'b0;
   logic [5:0] secs = 6'h00; // Seconds value before each tick
   logic hw, hr, rv, st, cp, srch, osc_n, wrap, busy, tick_o, clr_seen;
   logic [9:0] ha;
   logic [7:0] hd, rdat, code, acc;
   logic [8:0] raw = 9'h050; // Mid-range reading, between the thresholds
   int n_tick = 0; // Sample pulses seen
   int n_busy = 0; // Cycles with the busy output high
   int d_tick, d_busy; // Counts over one tsmp call
   int err_total = 0;
   int compares = 0;
   // Clock source
   always #2.5 clk_sys = ~clk_sys;
   // Count the one-cycle sample pulses and the cycles of busy that polling alone would miss
   always @(posedge clk_sys) begin
      n_tick <= n_tick + int'(tick_o);
      n_busy <= n_busy + int'(busy);
   end
   // Short phase counts keep each sample a few cycles long
   logger_mission_control_regs #(.WAKE_CYC(4), .CONV_CYC(4)) logger_mission_control_regs_i (
      .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_wr(hw), .i_rd(hr), .i_addr(ha),
      .i_wdata(hd), .o_rdata(rdat), .o_rvalid(rv), .i_mem_cmd(mem), .i_clear_cmd(clrc),
      .i_sec_tick(tick), .i_seconds(secs), .i_rtc_alarm(alarm), .i_raw_temp(raw),
      .i_raw_under(under), .i_raw_over(over), .i_forced_conv(1'b0), .o_osc_run_n(osc_n),
      .o_log_wrap_enable(wrap), .o_search_match(srch), .o_mission_start(st),
      .o_sample_tick(tick_o), .o_sample_code(code), .o_clear_pulse(cp), .o_busy_conv(busy));
   host_model host_model_i (
      .i_clk_sys(clk_sys), .i_rvalid(rv), .i_rdata(rdat), .o_wr(hw), .o_rd(hr),
      .o_addr(ha), .o_wdata(hd));
   // Compare and count
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Read one register and judge it
   task automatic rchk(input string n, input logic [9:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic ok;
      host_model_i.rd(a, d, ok);
      chk("rvalid", {7'h00, ok}, 8'h01);
      chk(n, d, e);
   endtask : rchk
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      host_model_i.wr(a, d);
   endtask : wr
   // One-cycle strobe: 0 seconds tick, 1 memory command, 2 clock alarm
   task automatic pls(input int k, input logic [5:0] s);
      @(posedge clk_sys);
      #1;
      secs = s;
      tick = (k == 0);
      mem = (k == 1);
      alarm = (k == 2);
      @(posedge clk_sys);
      #1;
      clr_seen = cp;
      tick = 1'b0;
      mem = 1'b0;
      alarm = 1'b0;
   endtask : pls
   // Tick, then poll status; bit 7 collects a low busy bit, others a high
   task automatic tsmp(input logic [5:0] s);
      logic [7:0] d;
      logic ok;
      int t0;
      int b0;
      t0 = n_tick;
      b0 = n_busy;
      pls(0, s);
      acc = 8'h00;
      for (int i = 0; i < 6; i++) begin
         host_model_i.rd(10'h214, d, ok);
         acc = acc | {~d[7], d[6:0]};
      end
      d_tick = n_tick - t0;
      d_busy = n_busy - b0;
   endtask : tsmp
   // Clear memory and start a one-minute mission
   task automatic go();
      wr(10'h20e, 8'h40);
      clrc = 1'b1;
      pls(1, secs);
      wr(10'h20e, 8'h00);
      wr(10'h20d, 8'h01);
      chk("start", {7'h00, st}, 8'h01);
   endtask : go
   task automatic t_reset();
      rchk("ctrl", 10'h20e, 8'h80);
      rchk("status", 10'h214, 8'h80);
      chk("osc", {7'h00, osc_n}, 8'h01);
      $display("done reset");
   endtask : t_reset
   task automatic t_ctrl();
      wr(10'h20e, 8'hff);
      rchk("ctrl ff", 10'h20e, 8'hdf);
      chk("wrap", {7'h00, wrap}, 8'h01);
      wr(10'h20e, 8'h00);
      rchk("ctrl 00", 10'h20e, 8'h00);
      chk("osc", {7'h00, osc_n}, 8'h00);
      chk("wrap", {7'h00, wrap}, 8'h00);
      $display("done ctrl");
   endtask : t_ctrl
   task automatic t_clear();
      wr(10'h20b, host_model_i.thr(-40));
      wr(10'h20c, host_model_i.thr(50));
      rchk("low thr", 10'h20b, 8'h28);
      rchk("high thr", 10'h20c, 8'h82);
      wr(10'h212, 8'h34);
      wr(10'h213, 8'h12);
      wr(10'h20d, 8'h05);
      rchk("dly lo", 10'h212, 8'h34);
      rchk("dly hi", 10'h213, 8'h12);
      rchk("no start", 10'h214, 8'h80);
      clrc = 1'b1;
      pls(1, secs);
      chk("unarmed clr", {7'h00, clr_seen}, 8'h00);
      rchk("unarmed st", 10'h214, 8'h80);
      wr(10'h20e, 8'h40);
      pls(1, secs);
      chk("clr pulse", {7'h00, clr_seen}, 8'h01);
      rchk("arm drop", 10'h20e, 8'h00);
      rchk("cleared", 10'h214, 8'hc0);
      rchk("rate", 10'h20d, 8'h00);
      rchk("dly lo", 10'h212, 8'h00);
      rchk("dly hi", 10'h213, 8'h00);
      $display("done clear");
   endtask : t_clear
   task automatic t_start();
      wr(10'h20d, 8'h01);
      chk("no sec", {7'h00, st}, 8'h00);
      pls(0, 6'h0a);
      wr(10'h20e, 8'h10);
      wr(10'h20d, 8'h03);
      chk("en off", {7'h00, st}, 8'h00);
      wr(10'h20e, 8'h00);
      wr(10'h212, 8'h01);
      wr(10'h20d, 8'h02);
      chk("start", {7'h00, st}, 8'h01);
      rchk("active", 10'h214, 8'ha0);
      $display("done start");
   endtask : t_start
   task automatic t_mission();
      tsmp(6'h1e);
      chk("mid minute", acc[4], 1'b0);
      tsmp(6'h3b);
      chk("delay", acc[4], 1'b0);
      chk("delay tick", 8'(d_tick), 8'h00);
      over = 1'b1;
      tsmp(6'h3b);
      chk("sip", acc[4], 1'b1);
      chk("busy low", acc[7], 1'b1);
      chk("busy cyc", 8'(d_busy), 8'h04);
      chk("tick", 8'(d_tick), 8'h01);
      chk("code hi", code, 8'hfa);
      rchk("thf", 10'h214, 8'ha2);
      over = 1'b0;
      tsmp(6'h3b);
      chk("spacing", acc[4], 1'b0);
      chk("no tick", 8'(d_tick), 8'h00);
      under = 1'b1;
      tsmp(6'h3b);
      chk("spaced", acc[4], 1'b1);
      chk("code lo", code, 8'h00);
      rchk("tlf", 10'h214, 8'ha6);
      under = 1'b0;
      $display("done mission");
   endtask : t_mission
   task automatic t_flags();
      pls(2, secs);
      rchk("taf", 10'h214, 8'ha7);
      wr(10'h214, 8'hff);
      rchk("w1 ignored", 10'h214, 8'ha7);
      wr(10'h20e, 8'h04);
      rchk("ctrl end", 10'h214, 8'h87);
      chk("tls", {7'h00, srch}, 8'h01);
      wr(10'h20e, 8'h02);
      chk("ths", {7'h00, srch}, 8'h01);
      wr(10'h20e, 8'h01);
      chk("tas", {7'h00, srch}, 8'h01);
      wr(10'h214, 8'h00);
      rchk("w0 clears", 10'h214, 8'h80);
      chk("no match", {7'h00, srch}, 8'h00);
      wr(10'h214, 8'hff);
      rchk("read only", 10'h214, 8'h80);
      wr(10'h20e, 8'h00);
      $display("done flags");
   endtask : t_flags
   task automatic t_end();
      go();
      wr(10'h214, 8'h00);
      rchk("mip w0", 10'h214, 8'h80);
      go();
      wr(10'h205, 8'h00);
      rchk("page wr", 10'h214, 8'h80);
      $display("done end");
   endtask : t_end
   // Verdict and end of run
   task automatic summarize();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   // Hang guard, far beyond the sequence length
   initial begin
      #200000;
      err_total++;
      summarize();
   end
   // Main sequence
   initial begin
      repeat (3) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      t_reset();
      t_ctrl();
      t_clear();
      t_start();
      t_mission();
      t_flags();
      t_end();
      summarize();
   end
endmodule : tb_logger_mission_control_regs
`default_nettype wire

// >>> verilog/conv_timer.sv
// Wake-up and conversion phase timer for one mission sample
`timescale 1ns/1ps
`default_nettype none
module conv_timer #(
   parameter int WAKE_CYC = logger_regs_pkg::WAKE_CYC,
   parameter int CONV_CYC = logger_regs_pkg::CONV_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_start,
   output logic o_waking,
   output logic o_converting,
   output logic o_done
);
   typedef enum logic [2:0] {
      T_IDLE = 3'b001,
      T_WAKE = 3'b010,
      T_CONV = 3'b100
   } tphase_t;
   typedef struct packed {
      tphase_t ph;
      logic [31:0] cnt;
      logic done;
   } tstate_t;
   tstate_t s_r;
   tstate_t s_nxt;
   // Phase sequencing; done is a single-cycle pulse at conversion end
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      case (s_r.ph)
         T_IDLE: begin
            if (i_start) begin
               s_nxt.ph = T_WAKE;
               s_nxt.cnt = 32'h0;
            end
         end
         T_WAKE: begin
            // Wake before conversion begins
            if (s_r.cnt >= 32'(WAKE_CYC - 1)) begin
               s_nxt.ph = T_CONV;
               s_nxt.cnt = 32'h0;
            end else begin
               s_nxt.cnt = s_r.cnt + 32'h1;
            end
         end
         T_CONV: begin
            if (s_r.cnt >= 32'(CONV_CYC - 1)) begin
               s_nxt.ph = T_IDLE;
               s_nxt.done = 1'b1;
            end else begin
               s_nxt.cnt = s_r.cnt + 32'h1;
            end
         end
         default: begin
            s_nxt.ph = T_IDLE;
         end
      endcase
   end
   // State register
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         s_r <= '{ph: T_IDLE, cnt: 32'h0, done: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end
   assign o_waking = (s_r.ph == T_WAKE);
   assign o_converting = (s_r.ph == T_CONV);
   assign o_done = s_r.done;
endmodule : conv_timer
`default_nettype wire

// >>> verilog/logger_mission_control_regs.sv
// Mission configuration and status register bank of the logger
`timescale 1ns/1ps
`default_nettype none
module logger_mission_control_regs #(
   parameter int WAKE_CYC = logger_regs_pkg::WAKE_CYC,
   parameter int CONV_CYC = logger_regs_pkg::CONV_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Register access from the serial transport
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [9:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   // Memory function command boundaries
   input wire logic i_mem_cmd,
   input wire logic i_clear_cmd,
   // Timebase from the clock block
   input wire logic i_sec_tick,
   input wire logic [5:0] i_seconds,
   input wire logic i_rtc_alarm,
   // Raw temperature from the sensor core
   input wire logic [8:0] i_raw_temp,
   input wire logic i_raw_under,
   input wire logic i_raw_over,
   input wire logic i_forced_conv,
   // To the memory and search blocks
   output logic o_osc_run_n,
   output logic o_log_wrap_enable,
   output logic o_search_match,
   output logic o_mission_start,
   output logic o_sample_tick,
   output logic [7:0] o_sample_code,
   output logic o_clear_pulse,
   output logic o_busy_conv
);
   typedef enum logic [2:0] {
      M_IDLE = 3'b001,
      M_DELAY = 3'b010,
      M_RUN = 3'b100
   } mphase_t;
   typedef struct packed {
      mphase_t ph;
      logic [7:0] low_thr;
      logic [7:0] high_thr;
      logic [7:0] rate;
      logic [7:0] ctrl;
      logic [15:0] delay;
      logic [7:0] readout;
      logic memory_cleared;
      logic mission_active;
      logic sample_active;
      logic conversion_busy_n;
      logic low_temp_flag;
      logic high_temp_flag;
      logic timer_alarm_flag;
      logic osc_second_seen;
      logic [7:0] minute_cnt;
      logic mission_conv;
      logic [7:0] rdata;
      logic rvalid;
      logic start_p;
      logic sample_p;
      logic [7:0] code;
      logic clear_p;
   } rstate_t;
   rstate_t s_r;
   rstate_t s_nxt;
   logic conv_start; // Request to the phase timer
   logic t_waking; // Wake phase of a conversion
   logic t_conv; // Measuring phase
   logic t_done; // Result ready pulse
   logic minute_edge; // Seconds rollover 59 to 00
   logic [7:0] result_code; // Clamped result
   logic page_write; // Write to the mission-ending range

   // Clamp the raw reading into the one-byte code space
   function automatic logic [7:0] clamp_code(input logic [8:0] raw, input logic under,
                                             input logic over);
      logic [7:0] c;
      c = raw[7:0];
      if (under || (raw == 9'h0)) begin
         c = logger_regs_pkg::TEMP_UNDER;
      end else if (over || (raw > {1'b0, logger_regs_pkg::TEMP_MAX_OK})) begin
         c = logger_regs_pkg::TEMP_OVER;
      end
      return c;
   endfunction : clamp_code

   assign result_code = clamp_code(i_raw_temp, i_raw_under, i_raw_over);
   assign minute_edge = i_sec_tick && (i_seconds == logger_regs_pkg::SEC_LAST);
   assign page_write = i_wr && (i_addr >= logger_regs_pkg::ADDR_PAGE_LO)
                       && (i_addr <= logger_regs_pkg::ADDR_PAGE_HI);

   conv_timer #(
      .WAKE_CYC(WAKE_CYC),
      .CONV_CYC(CONV_CYC)
   ) u_conv_timer (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_start(conv_start),
      .o_waking(t_waking),
      .o_converting(t_conv),
      .o_done(t_done)
   );

   // All register and mission behaviour
   always_comb begin
      s_nxt = s_r;
      s_nxt.start_p = 1'b0;
      s_nxt.sample_p = 1'b0;
      s_nxt.clear_p = 1'b0;
      s_nxt.rvalid = 1'b0;
      conv_start = 1'b0;
      // Oscillator must run one second before a start is honoured
      if (s_r.ctrl[logger_regs_pkg::CTL_OSC]) begin
         s_nxt.osc_second_seen = 1'b0;
      end else if (i_sec_tick) begin
         s_nxt.osc_second_seen = 1'b1;
      end
      // Register writes
      if (i_wr) begin
         if (i_addr == logger_regs_pkg::ADDR_LOW_THR) begin
            s_nxt.low_thr = i_wdata;
         end else if (i_addr == logger_regs_pkg::ADDR_HIGH_THR) begin
            s_nxt.high_thr = i_wdata;
         end else if (i_addr == logger_regs_pkg::ADDR_RATE) begin
            s_nxt.rate = i_wdata;
            if ((i_wdata != 8'h00) && s_r.memory_cleared && !s_r.mission_active
                && !s_r.ctrl[logger_regs_pkg::CTL_EN] && s_r.osc_second_seen) begin
               // Start only from a cleared memory with mission enabled low
               s_nxt.ph = M_DELAY;
               s_nxt.memory_cleared = 1'b0;
               s_nxt.start_p = 1'b1;
               s_nxt.minute_cnt = 8'h00;
            end
         end else if (i_addr == logger_regs_pkg::ADDR_CTRL) begin
            s_nxt.ctrl = i_wdata & logger_regs_pkg::CTL_WMASK;
         end else if (i_addr == logger_regs_pkg::ADDR_DLY_LO) begin
            s_nxt.delay[7:0] = i_wdata;
         end else if (i_addr == logger_regs_pkg::ADDR_DLY_HI) begin
            s_nxt.delay[15:8] = i_wdata;
         end else if (i_addr == logger_regs_pkg::ADDR_STATUS) begin
            // Write-zero-only flags; a set in the same cycle wins below
            if (!i_wdata[logger_regs_pkg::ST_MIP]) begin
               s_nxt.ph = M_IDLE;
            end
            if (!i_wdata[logger_regs_pkg::ST_TLF]) begin
               s_nxt.low_temp_flag = 1'b0;
            end
            if (!i_wdata[logger_regs_pkg::ST_THF]) begin
               s_nxt.high_temp_flag = 1'b0;
            end
            if (!i_wdata[logger_regs_pkg::ST_TAF]) begin
               s_nxt.timer_alarm_flag = 1'b0;
            end
         end
         // Any write into the page ends a running mission, except on the minute edge that moves M_DELAY to M_RUN
         if (page_write && s_r.mission_active) begin
            s_nxt.ph = M_IDLE;
         end
      end
      // Memory function commands consume the arm bit
      if (i_mem_cmd) begin
         if (i_clear_cmd && s_r.ctrl[logger_regs_pkg::CTL_CLR] && !s_r.mission_active) begin
            s_nxt.rate = 8'h00;
            s_nxt.delay = 16'h0000;
            s_nxt.memory_cleared = 1'b1;
            s_nxt.clear_p = 1'b1;
         end
         s_nxt.ctrl[logger_regs_pkg::CTL_CLR] = 1'b0;
      end
      // Mission sequencing on minute boundaries
      case (s_r.ph)
         M_IDLE: begin
         end
         M_DELAY: begin
            if (minute_edge) begin
               if (s_r.delay == 16'h0000) begin
                  s_nxt.ph = M_RUN;
                  s_nxt.minute_cnt = 8'h00;
                  conv_start = !s_r.mission_conv && t_waking == 1'b0 && !t_conv;
                  s_nxt.mission_conv = conv_start;
               end else begin
                  s_nxt.delay = s_r.delay - 16'h0001;
               end
            end
         end
         M_RUN: begin
            if (minute_edge) begin
               if (s_r.minute_cnt + 8'h01 >= s_r.rate) begin
                  s_nxt.minute_cnt = 8'h00;
                  conv_start = !t_waking && !t_conv;
                  s_nxt.mission_conv = conv_start;
               end else begin
                  s_nxt.minute_cnt = s_r.minute_cnt + 8'h01;
               end
            end
         end
         default: begin
            s_nxt.ph = M_IDLE;
         end
      endcase
      if (i_forced_conv && !s_r.mission_active && !t_waking && !t_conv) begin
         conv_start = 1'b1;
         s_nxt.mission_conv = 1'b0;
      end
      s_nxt.mission_active = (s_nxt.ph != M_IDLE);
      // Conversion status bits
      s_nxt.sample_active = s_r.mission_conv && (t_waking || t_conv);
      s_nxt.conversion_busy_n = !t_conv;
      if (t_done) begin
         s_nxt.readout = result_code;
         s_nxt.conversion_busy_n = 1'b1;
         if (s_r.mission_conv) begin
            s_nxt.sample_p = 1'b1;
            s_nxt.code = result_code;
            s_nxt.mission_conv = 1'b0;
            if (result_code <= s_r.low_thr) begin
               s_nxt.low_temp_flag = 1'b1;
            end
            if (result_code >= s_r.high_thr) begin
               s_nxt.high_temp_flag = 1'b1;
            end
         end
      end
      if (i_rtc_alarm) begin
         s_nxt.timer_alarm_flag = 1'b1;
      end
      // Register reads
      if (i_rd) begin
         s_nxt.rvalid = 1'b1;
         if (i_addr == logger_regs_pkg::ADDR_LOW_THR) begin
            s_nxt.rdata = s_r.low_thr;
         end else if (i_addr == logger_regs_pkg::ADDR_HIGH_THR) begin
            s_nxt.rdata = s_r.high_thr;
         end else if (i_addr == logger_regs_pkg::ADDR_RATE) begin
            s_nxt.rdata = s_r.rate;
         end else if (i_addr == logger_regs_pkg::ADDR_CTRL) begin
            s_nxt.rdata = s_r.ctrl;
         end else if (i_addr == logger_regs_pkg::ADDR_READOUT) begin
            s_nxt.rdata = s_r.readout;
         end else if (i_addr == logger_regs_pkg::ADDR_DLY_LO) begin
            s_nxt.rdata = s_r.delay[7:0];
         end else if (i_addr == logger_regs_pkg::ADDR_DLY_HI) begin
            s_nxt.rdata = s_r.delay[15:8];
         end else if (i_addr == logger_regs_pkg::ADDR_STATUS) begin
            s_nxt.rdata = {s_r.conversion_busy_n, s_r.memory_cleared, s_r.mission_active,
                           s_r.sample_active, 1'b0, s_r.low_temp_flag,
                           s_r.high_temp_flag, s_r.timer_alarm_flag};
         end else begin
            s_nxt.rdata = 8'h00; // Unmapped reads as zero
         end
      end
   end

   // State register; control resets with the oscillator stopped
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         s_r <= '0;
         s_r.ph <= M_IDLE;
         s_r.ctrl <= logger_regs_pkg::CTL_RESET;
         s_r.conversion_busy_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_rdata = s_r.rdata;
   assign o_rvalid = s_r.rvalid;
   assign o_osc_run_n = s_r.ctrl[logger_regs_pkg::CTL_OSC];
   assign o_log_wrap_enable = s_r.ctrl[logger_regs_pkg::CTL_WRAP];
   // Conditional search answer, one term per enable bit
   assign o_search_match = (s_r.ctrl[logger_regs_pkg::CTL_TLS] && s_r.low_temp_flag)
                        || (s_r.ctrl[logger_regs_pkg::CTL_THS] && s_r.high_temp_flag)
                        || (s_r.ctrl[logger_regs_pkg::CTL_TAS] && s_r.timer_alarm_flag);
   assign o_mission_start = s_r.start_p;
   assign o_sample_tick = s_r.sample_p;
   assign o_sample_code = s_r.code;
   assign o_clear_pulse = s_r.clear_p;
   assign o_busy_conv = !s_r.conversion_busy_n;

   a_bit5_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      s_r.ctrl[logger_regs_pkg::CTL_RSVD] == 1'b0) else $error("ctrl bit5 set");
   a_ctrl_end_mission: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_wr && i_addr == logger_regs_pkg::ADDR_CTRL && s_r.mission_active)
      |=> !s_r.mission_active) else $error("ctrl write kept mission");
   a_start_needs_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(s_r.mission_active) |-> $past(s_r.memory_cleared) && !s_r.memory_cleared)
      else $error("start without clear");
   a_start_needs_en: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(s_r.mission_active) |-> !$past(s_r.ctrl[logger_regs_pkg::CTL_EN]))
      else $error("start with enable high");
   a_arm_drops: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_mem_cmd |=> !s_r.ctrl[logger_regs_pkg::CTL_CLR]) else $error("arm kept");
   a_clear_zeroes: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      s_r.clear_p |-> s_r.rate == 8'h00 && s_r.memory_cleared) else $error("clear bad");
   a_alarm_sets: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_rtc_alarm |=> s_r.timer_alarm_flag) else $error("alarm lost");
   a_code_range: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      s_r.sample_p |-> s_r.code <= logger_regs_pkg::TEMP_OVER) else $error("code range");
   a_mip_wr_one: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (!s_r.mission_active && !s_r.start_p) |=> (!s_r.mission_active || s_r.start_p))
      else $error("mission set by write");
endmodule : logger_mission_control_regs
`default_nettype wire
